// File: rtl/seq_tracker_pkg.sv
// Purpose: shared constants and types for the cell sequence tracker
// Assumes: 3-bit sequence numbers, modulo 8
// Notes: states outside this block are named so next-state can point at them
package seq_tracker_pkg;
    localparam int SEQ_W = 3;
    localparam int CNT_W = 3;
    localparam int FILL_W = 8;
    localparam logic [2:0] SEQ_ONE = 3'h1;
    localparam logic [2:0] SEQ_TWO = 3'h2;
    localparam logic [2:0] SEQ_RST = 3'h0;
    localparam logic [2:0] CNT_RST = 3'h0;
    localparam logic [7:0] FILL_RST = 8'h00;
    typedef enum logic [2:0] {
        ST_START,
        ST_OUT_OF_SYNC,
        ST_SYNC,
        ST_INVALID,
        ST_GAP_PENDING,
        ST_SINGLE_GAP,
        ST_LATE_WAIT
    } seq_state_t;
endpackage

// File: rtl/dummy_inserter.sv
// Purpose: emits a requested number of dummy cells, one per clock
// Assumes: a new request only comes while idle
// Notes: each dummy carries the programmed fill value
`timescale 1ns/1ns
module dummy_inserter #(
    parameter int CNT_W = 3,
    parameter int FILL_W = 8
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic loadValid,
    input wire logic [CNT_W-1:0] loadCount,
    input wire logic [FILL_W-1:0] fillValue,
    output logic dummyValid,
    output logic [FILL_W-1:0] dummyData,
    output logic busy
);
    logic [CNT_W-1:0] left_r;

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            left_r <= '0;
            dummyValid <= 1'b0;
            dummyData <= '0;
        end
        else if (loadValid && loadCount != '0)
        begin
            left_r <= CNT_W'(loadCount - 1'b1);
            dummyValid <= 1'b1;
            dummyData <= fillValue;
        end
        else if (left_r != '0)
        begin
            left_r <= CNT_W'(left_r - 1'b1);
            dummyValid <= 1'b1;
            dummyData <= fillValue;
        end
        else
        begin
            dummyValid <= 1'b0;
        end
    end

    assign busy = (left_r != '0);
endmodule

// File: rtl/udt_cell_sequence_tracker.sv
// Purpose: sync, invalid and gap-pending states of the sequence tracker
// Assumes: one cell event per cellValid pulse, same clock domain
// Notes: other states live outside; they hand in via stateIn
`timescale 1ns/1ns
module udt_cell_sequence_tracker
    import seq_tracker_pkg::*;
#(
    parameter int FILL_W = seq_tracker_pkg::FILL_W
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic cellValid,
    input wire logic seqValid,
    input wire logic [seq_tracker_pkg::SEQ_W-1:0] seqNum,
    input wire seq_tracker_pkg::seq_state_t stateIn,
    input wire logic [seq_tracker_pkg::SEQ_W-1:0] lastGoodIn,
    input wire logic [seq_tracker_pkg::SEQ_W-1:0] lastRxIn,
    input wire logic lateTimeout,
    input wire logic late_arrival_check_enable,
    input wire logic [FILL_W-1:0] fillValue,
    output seq_tracker_pkg::seq_state_t stateOut,
    output logic [seq_tracker_pkg::SEQ_W-1:0] lastGoodOut,
    output logic [seq_tracker_pkg::SEQ_W-1:0] lastRxOut,
    output logic acceptCell,
    output logic discardCell,
    output logic sequence_error_event,
    output logic lostCellError,
    output logic [seq_tracker_pkg::CNT_W-1:0] lostCount,
    output logic misinsertedError,
    output logic timeoutEnable,
    output logic dummyInsert,
    output logic [FILL_W-1:0] dummyData
);
    import seq_tracker_pkg::*;

    function automatic logic [SEQ_W-1:0] seqAdd(input logic [SEQ_W-1:0] a, input logic [SEQ_W-1:0] b);
        seqAdd = SEQ_W'(a + b);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // decision logic

    seq_state_t nxtState;
    logic acc, dis, seqErr, lostErr, misErr, tEn, padLoad;
    logic [CNT_W-1:0] padCount;
    logic [SEQ_W-1:0] good_nxt, rx_nxt;
    logic busy;
    logic inSeqGood, inSeqRx, twoAbove, oneAbove;
    logic lateFire;

    assign inSeqGood = (seqNum == seqAdd(lastGoodIn, SEQ_ONE));
    assign oneAbove = (seqNum == seqAdd(lastGoodIn, SEQ_TWO));
    assign twoAbove = (seqNum == seqAdd(lastGoodIn, SEQ_TWO));
    assign inSeqRx = (seqNum == seqAdd(lastRxIn, SEQ_ONE));
    assign lateFire = (stateIn == ST_SYNC) && lateTimeout && late_arrival_check_enable;

    always_comb
    begin
        nxtState = stateIn;
        acc = 1'b0;
        dis = 1'b0;
        seqErr = 1'b0;
        lostErr = 1'b0;
        misErr = 1'b0;
        tEn = 1'b0;
        padLoad = 1'b0;
        padCount = CNT_RST;
        good_nxt = lastGoodIn;
        rx_nxt = lastRxIn;
        case (stateIn)
            ST_SYNC:
            begin
                if (lateFire)
                begin
                    padLoad = 1'b1;
                    padCount = CNT_W'(1);
                    nxtState = ST_LATE_WAIT;
                end
                else if (cellValid)
                begin
                    acc = 1'b1;
                    rx_nxt = seqNum;
                    if (!seqValid)
                    begin
                        nxtState = ST_INVALID;
                        rx_nxt = lastRxIn;
                    end
                    else if (inSeqGood)
                    begin
                        good_nxt = seqNum;
                        tEn = 1'b1;
                    end
                    else if (oneAbove)
                    begin
                        padLoad = 1'b1;
                        padCount = CNT_W'(1);
                        seqErr = 1'b1;
                        nxtState = ST_SINGLE_GAP;
                    end
                    else
                    begin
                        seqErr = 1'b1;
                        nxtState = ST_GAP_PENDING;
                    end
                end
            end
            ST_INVALID, ST_GAP_PENDING:
            begin
                if (cellValid)
                begin
                    if (!seqValid)
                    begin
                        dis = 1'b1;
                        nxtState = ST_START;
                    end
                    else if (stateIn == ST_INVALID && inSeqGood)
                    begin
                        dis = 1'b1;
                        misErr = 1'b1;
                        tEn = 1'b1;
                        nxtState = ST_SYNC;
                    end
                    else if (stateIn == ST_GAP_PENDING && inSeqRx)
                    begin
                        padLoad = 1'b1;
                        padCount = CNT_W'(seqNum - seqAdd(lastGoodIn, SEQ_ONE) - SEQ_ONE);
                        acc = 1'b1;
                        lostErr = 1'b1;
                        tEn = 1'b1;
                        good_nxt = seqNum;
                        rx_nxt = seqNum;
                        nxtState = ST_SYNC;
                    end
                    else if (twoAbove)
                    begin
                        acc = 1'b1;
                        tEn = 1'b1;
                        good_nxt = seqNum;
                        rx_nxt = seqNum;
                        nxtState = ST_SYNC;
                    end
                    else
                    begin
                        dis = 1'b1;
                        nxtState = ST_OUT_OF_SYNC;
                    end
                end
            end
            default:
            begin
                nxtState = stateIn;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // registered outputs

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            stateOut <= ST_START;
            lastGoodOut <= SEQ_RST;
            lastRxOut <= SEQ_RST;
        end
        else
        begin
            stateOut <= nxtState;
            lastGoodOut <= good_nxt;
            lastRxOut <= rx_nxt;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            acceptCell <= 1'b0;
            discardCell <= 1'b0;
            sequence_error_event <= 1'b0;
            lostCellError <= 1'b0;
            lostCount <= CNT_RST;
            misinsertedError <= 1'b0;
            timeoutEnable <= 1'b0;
        end
        else
        begin
            acceptCell <= acc;
            discardCell <= dis;
            sequence_error_event <= seqErr;
            lostCellError <= lostErr;
            lostCount <= lostErr ? padCount : CNT_RST;
            misinsertedError <= misErr;
            timeoutEnable <= tEn && nxtState == ST_SYNC;
        end
    end

    dummy_inserter #(.CNT_W(CNT_W), .FILL_W(FILL_W)) padUnit (
        .clk(clk),
        .resetn(resetn),
        .loadValid(padLoad && !busy),
        .loadCount(padCount),
        .fillValue(fillValue),
        .dummyValid(dummyInsert),
        .dummyData(dummyData),
        .busy(busy)
    );

    ////////////////////////////////////////////////////////////////////////
    // checks

    late_pad_a: assert property (@(posedge clk) disable iff (!resetn)
        lateFire |=> dummyInsert && stateOut == ST_LATE_WAIT ##1 !dummyInsert)
        else $error("late timeout did not give one dummy");
    inv_acc_a: assert property (@(posedge clk) disable iff (!resetn)
        (stateIn == ST_SYNC && cellValid && !seqValid && !lateFire) |=> acceptCell && stateOut == ST_INVALID)
        else $error("invalid cell in sync not accepted");
    sync_stay_a: assert property (@(posedge clk) disable iff (!resetn)
        (stateIn == ST_SYNC && !lateFire && cellValid && seqValid && inSeqGood)
        |=> acceptCell && timeoutEnable && stateOut == ST_SYNC)
        else $error("in-sequence cell mishandled");
    single_gap_a: assert property (@(posedge clk) disable iff (!resetn)
        (stateIn == ST_SYNC && !lateFire && cellValid && seqValid && oneAbove)
        |=> dummyInsert && sequence_error_event && stateOut == ST_SINGLE_GAP)
        else $error("single loss not padded");
    gap_enter_a: assert property (@(posedge clk) disable iff (!resetn)
        (stateIn == ST_SYNC && !lateFire && cellValid && seqValid && !inSeqGood && !oneAbove)
        |=> !dummyInsert && sequence_error_event && stateOut == ST_GAP_PENDING)
        else $error("out of order cell mishandled");
    misins_a: assert property (@(posedge clk) disable iff (!resetn)
        (stateIn == ST_INVALID && cellValid && seqValid && inSeqGood)
        |=> discardCell && misinsertedError && stateOut == ST_SYNC)
        else $error("misinsertion mishandled");
    prot_recover_a: assert property (@(posedge clk) disable iff (!resetn)
        ((stateIn == ST_INVALID || stateIn == ST_GAP_PENDING) && cellValid && seqValid && twoAbove
        && !(stateIn == ST_GAP_PENDING && inSeqRx))
        |=> acceptCell && timeoutEnable && stateOut == ST_SYNC && lastGoodOut == $past(seqNum))
        else $error("protection failure recovery mishandled");
    discard_start_a: assert property (@(posedge clk) disable iff (!resetn)
        ((stateIn == ST_INVALID || stateIn == ST_GAP_PENDING) && cellValid && !seqValid)
        |=> discardCell && !acceptCell && stateOut == ST_START)
        else $error("invalid number not discarded");
    arm_cause_a: assert property (@(posedge clk) disable iff (!resetn)
        timeoutEnable |-> acceptCell || discardCell)
        else $error("timeout armed without a cell");
    multi_loss_a: assert property (@(posedge clk) disable iff (!resetn)
        lostCellError |-> dummyInsert == (lostCount != CNT_RST) && timeoutEnable)
        else $error("lost cell padding mismatch");
    arm_sync_a: assert property (@(posedge clk) disable iff (!resetn)
        timeoutEnable |-> stateOut == ST_SYNC)
        else $error("timeout armed outside sync");
    late_gate_a: assert property (@(posedge clk) disable iff (!resetn)
        (stateIn == ST_SYNC && !late_arrival_check_enable && !cellValid) |=> stateOut == ST_SYNC)
        else $error("late transition without enable");
endmodule

// File: verif/buffer_writer_model.sv
// Purpose: buffer writer at the tracker's far side; counts cells written
// Assumes: one accepted or dummy cell per pulse, same clock as the tracker
// Notes: clear zeroes the counts before each scenario
`timescale 1ns/1ns
module buffer_writer_model
(
    input wire logic clk,
    input wire logic clear,
    input wire logic acceptCell,
    input wire logic dummyInsert,
    input wire logic [7:0] dummyData,
    input wire logic [7:0] fillValue,
    output int nAccept,
    output int nDummy,
    output int nBadFill
);
    always_ff @(posedge clk)
    begin
        if (clear)
        begin
            nAccept <= 0;
            nDummy <= 0;
            nBadFill <= 0;
        end
        else
        begin
            if (acceptCell === 1'b1)
                nAccept <= nAccept + 1;
            if (dummyInsert === 1'b1)
                nDummy <= nDummy + 1;
            // a dummy whose payload is not the fill value is a bad write
            if (dummyInsert === 1'b1 && dummyData !== fillValue)
                nBadFill <= nBadFill + 1;
        end
    end
endmodule

// File: verif/tb_top.sv
// Purpose: self-checking bench for the cell sequence tracker
// Assumes: stateIn and context driven directly per scenario
// Notes: decision outputs checked one cycle after the cell, counts after 9 more
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin nErrors++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, (a), (b)); end end
module tb_top;
    import seq_tracker_pkg::*;
    logic clk, resetn, cellValid, seqValid, lateTimeout, lateCheckEn, clear;
    logic [2:0] seqNum, lastGoodIn, lastRxIn, lastGoodOut, lastRxOut, lostCount;
    seq_state_t stateIn, stateOut;
    logic acceptCell, discardCell, seqErr, lostErr, misErr, toEn, dummyInsert;
    logic [7:0] fillValue, dummyData;
    int nErrors, checks, nAccept, nDummy, nBadFill;

    udt_cell_sequence_tracker u_udt_cell_sequence_tracker (.clk(clk), .resetn(resetn), .cellValid(cellValid),
        .seqValid(seqValid), .seqNum(seqNum), .stateIn(stateIn), .lastGoodIn(lastGoodIn), .lastRxIn(lastRxIn),
        .lateTimeout(lateTimeout), .late_arrival_check_enable(lateCheckEn), .fillValue(fillValue),
        .stateOut(stateOut), .lastGoodOut(lastGoodOut), .lastRxOut(lastRxOut), .acceptCell(acceptCell),
        .discardCell(discardCell), .sequence_error_event(seqErr), .lostCellError(lostErr),
        .lostCount(lostCount), .misinsertedError(misErr), .timeoutEnable(toEn), .dummyInsert(dummyInsert),
        .dummyData(dummyData));
    buffer_writer_model u_buffer_writer_model (.clk(clk), .clear(clear), .acceptCell(acceptCell),
        .dummyInsert(dummyInsert), .dummyData(dummyData), .fillValue(fillValue), .nAccept(nAccept),
        .nDummy(nDummy), .nBadFill(nBadFill));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic finish_test;
        if (nErrors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // one event in, decision outputs and written cells judged
    task automatic send(input seq_state_t st, input logic [2:0] lg, lr, input logic sv, cv, lt,
        input logic [2:0] sn, input seq_state_t est, input logic acc, dis, se, lost, mis, to, input int nd,
        input logic [5:0] ectx);
        @(posedge clk);
        clear <= 1'b1;
        stateIn <= st;
        lastGoodIn <= lg;
        lastRxIn <= lr;
        seqValid <= sv;
        cellValid <= cv;
        lateTimeout <= lt;
        seqNum <= sn;
        @(posedge clk);
        clear <= 1'b0;
        cellValid <= 1'b0;
        lateTimeout <= 1'b0;
        #1;
        `CHK(stateOut, est)
        `CHK({acceptCell, discardCell, seqErr, lostErr, misErr, toEn}, {acc, dis, se, lost, mis, to})
        `CHK({lastGoodOut, lastRxOut}, ectx)
        if (lost)
            `CHK(lostCount, nd[2:0])
        repeat (9) @(posedge clk);
        #1;
        `CHK(nDummy, nd)
        `CHK(nAccept, int'(acc))
        `CHK(nBadFill, 0)
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_sync_cells;
        send(ST_SYNC, 3'h7, 3'h7, 1'b1, 1'b1, 1'b0, 3'h0, ST_SYNC, 1, 0, 0, 0, 0, 1, 0, 6'h00);
        send(ST_SYNC, 3'h2, 3'h2, 1'b0, 1'b1, 1'b0, 3'h5, ST_INVALID, 1, 0, 0, 0, 0, 0, 0, 6'h12);
        send(ST_SYNC, 3'h6, 3'h6, 1'b1, 1'b1, 1'b0, 3'h0, ST_SINGLE_GAP, 1, 0, 1, 0, 0, 0, 1, 6'h30);
        send(ST_SYNC, 3'h1, 3'h1, 1'b1, 1'b1, 1'b0, 3'h5, ST_GAP_PENDING, 1, 0, 1, 0, 0, 0, 0, 6'h0D);
    endtask

    task automatic t_recovery;
        send(ST_INVALID, 3'h3, 3'h6, 1'b1, 1'b1, 1'b0, 3'h4, ST_SYNC, 0, 1, 0, 0, 1, 1, 0, 6'h1E);
        send(ST_INVALID, 3'h3, 3'h3, 1'b1, 1'b1, 1'b0, 3'h5, ST_SYNC, 1, 0, 0, 0, 0, 1, 0, 6'h2D);
        send(ST_GAP_PENDING, 3'h7, 3'h4, 1'b1, 1'b1, 1'b0, 3'h1, ST_SYNC, 1, 0, 0, 0, 0, 1, 0, 6'h09);
    endtask

    task automatic t_discards;
        send(ST_INVALID, 3'h3, 3'h3, 1'b0, 1'b1, 1'b0, 3'h4, ST_START, 0, 1, 0, 0, 0, 0, 0, 6'h1B);
        send(ST_INVALID, 3'h3, 3'h3, 1'b1, 1'b1, 1'b0, 3'h7, ST_OUT_OF_SYNC, 0, 1, 0, 0, 0, 0, 0, 6'h1B);
        send(ST_GAP_PENDING, 3'h2, 3'h6, 1'b0, 1'b1, 1'b0, 3'h7, ST_START, 0, 1, 0, 0, 0, 0, 0, 6'h16);
        send(ST_GAP_PENDING, 3'h2, 3'h6, 1'b1, 1'b1, 1'b0, 3'h1, ST_OUT_OF_SYNC, 0, 1, 0, 0, 0, 0, 0, 6'h16);
    endtask

    task automatic t_multi_loss;
        @(posedge clk);
        fillValue <= 8'h5A;
        send(ST_GAP_PENDING, 3'h2, 3'h6, 1'b1, 1'b1, 1'b0, 3'h7, ST_SYNC, 1, 0, 0, 1, 0, 1, 3, 6'h3F);
        send(ST_GAP_PENDING, 3'h7, 3'h4, 1'b1, 1'b1, 1'b0, 3'h5, ST_SYNC, 1, 0, 0, 1, 0, 1, 4, 6'h2D);
    endtask

    task automatic t_late;
        @(posedge clk);
        lateCheckEn <= 1'b1;
        send(ST_SYNC, 3'h1, 3'h1, 1'b1, 1'b0, 1'b1, 3'h0, ST_LATE_WAIT, 0, 0, 0, 0, 0, 0, 1, 6'h09);
        send(ST_START, 3'h1, 3'h1, 1'b1, 1'b0, 1'b1, 3'h0, ST_START, 0, 0, 0, 0, 0, 0, 0, 6'h09);
        @(posedge clk);
        lateCheckEn <= 1'b0;
        send(ST_SYNC, 3'h1, 3'h1, 1'b1, 1'b0, 1'b1, 3'h0, ST_SYNC, 0, 0, 0, 0, 0, 0, 0, 6'h09);
    endtask

    // mid-run reset with a cell offered; state is parked at start before release
    task automatic t_reset;
        @(posedge clk);
        resetn <= 1'b0;
        stateIn <= ST_SYNC;
        lastGoodIn <= 3'h0;
        seqValid <= 1'b1;
        seqNum <= 3'h1;
        cellValid <= 1'b1;
        @(posedge clk);
        stateIn <= ST_START;
        cellValid <= 1'b0;
        #1;
        `CHK({stateOut, lastGoodOut, lastRxOut}, {ST_START, 3'h0, 3'h0})
        `CHK({acceptCell, discardCell, seqErr, lostErr, misErr, toEn, dummyInsert}, 7'h00)
        @(posedge clk);
        resetn <= 1'b1;
        send(ST_SYNC, 3'h3, 3'h3, 1'b1, 1'b1, 1'b0, 3'h4, ST_SYNC, 1, 0, 0, 0, 0, 1, 0, 6'h24);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        resetn = 1'b0;
        cellValid = 1'b0;
        seqValid = 1'b0;
        seqNum = 3'h0;
        stateIn = ST_START;
        lastGoodIn = 3'h0;
        lastRxIn = 3'h0;
        lateTimeout = 1'b0;
        lateCheckEn = 1'b0;
        fillValue = 8'hA5;
        clear = 1'b1;
        nErrors = 0;
        checks = 0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        t_sync_cells();
        t_recovery();
        t_discards();
        t_multi_loss();
        t_late();
        t_reset();
        finish_test();
    end

    // about 200 cycles expected; cut a hang well beyond that
    initial
    begin
        repeat (2000) @(posedge clk);
        nErrors++;
        finish_test();
    end
endmodule
